// ### hdl/indicator_map.vh
// Register offsets, field positions and reset values for the indicator drive block
`ifndef INDICATOR_MAP_VH
`define INDICATOR_MAP_VH
`define ADDR_LINK_ENABLE        8'h72
`define ADDR_POLARITY           8'h73
`define ADDR_DRIVE_REQUEST      8'h74
`define ADDR_LINK_TRANSITION    8'h77
`define ADDR_DUTY_MIRROR        8'h79
`define ADDR_BEHAVIOR           8'h81
`define ADDR_DUTY_LIMITS        8'h90
`define ADDR_CONFIG             8'h91
`define ADDR_LAMP_STATE         8'h92
`define CFG_INV_LINK_BIT        0
`define CFG_BLOCK_POL_MIR_BIT   1
`define RST_LAMP3               3'h0
`define RST_BEHAVIOR            6'h00
`define RST_MIN_DUTY            4'h0
`define RST_MAX_DUTY            4'hf
`define RST_CONFIG              2'h0
`define PWM_PERIOD_STEPS        5'h10
`define PWM_TICK_DIV            8'h18
`endif

// ### hdl/lamp_pwm.v
// Duty-cycle pulse generator for one indicator lamp
module lamp_pwm #(
  parameter STEP_BITS = 4
) (
  input  wire                 clk,
  input  wire                 nrst,
  input  wire                 tick,
  input  wire [STEP_BITS-1:0] phase,
  input  wire [STEP_BITS-1:0] duty,
  input  wire                 full,
  output reg                  active_reg
);
  // Active for duty steps of each period; full forces constant activity
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active_reg <= 1'b0;
    end else if (tick) begin
      active_reg <= full | (phase < duty);
    end
  end
endmodule

// ### hdl/indicator_drive_control.v
// Indicator lamp drive control: registers, link logic, polarity, mirror and PWM
module indicator_drive_control #(
  parameter STEP_BITS = 4,
  parameter TICK_DIV  = 8'h18
) (
  input  wire       clk,
  input  wire       nrst,
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  input  wire       touch_input_1,
  input  wire       touch_input_2,
  input  wire       touch_input_3,
  output reg  [2:0] lamp_out,
  output reg  [2:0] lamp_oe_n
);
`include "indicator_map.vh"

  reg [2:0] link_reg;
  reg [2:0] polarity_reg;
  reg [2:0] drive_reg;
  reg [2:0] transition_reg;
  reg [2:0] mirror_reg;
  reg [5:0] behavior_reg;
  reg [3:0] min_duty_reg;
  reg [3:0] max_duty_reg;
  reg [1:0] config_reg;
  reg [2:0] touch_meta_reg;
  reg [2:0] touch_sync_reg;
  reg [2:0] touch_prev_reg;
  reg [2:0] link_prev_reg;
  reg [2:0] hold_reg;
  reg [2:0] actuate_reg;
  reg [7:0] div_reg;
  reg       tick_reg;
  reg [3:0] phase_reg;
  wire [2:0] pwm_active;
  wire [2:0] touch_raw;
  wire [2:0] new_link;
  reg  [2:0] actuate_next;
  reg  [3:0] duty_sel [0:2];
  integer i;
  integer j;
  integer m;

  assign touch_raw = {touch_input_3, touch_input_2, touch_input_1};
  assign new_link  = link_reg & ~link_prev_reg;

  function [3:0] ref_duty;
    input [3:0] d;
    input       mir;
    begin
      ref_duty = mir ? (4'hf - d) : d;
    end
  endfunction

  function wr_hit;
    input [7:0] a;
    input [7:0] target;
    begin
      wr_hit = (a == target);
    end
  endfunction

  // Register writes; polarity write drags mirror along
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link_reg       <= `RST_LAMP3;
      polarity_reg   <= `RST_LAMP3;
      drive_reg      <= `RST_LAMP3;
      transition_reg <= `RST_LAMP3;
      mirror_reg     <= `RST_LAMP3;
      behavior_reg   <= `RST_BEHAVIOR;
      min_duty_reg   <= `RST_MIN_DUTY;
      max_duty_reg   <= `RST_MAX_DUTY;
      config_reg     <= `RST_CONFIG;
    end else if (wr) begin
      if (wr_hit(addr, `ADDR_LINK_ENABLE))
        link_reg <= wdata[2:0];
      if (wr_hit(addr, `ADDR_POLARITY)) begin
        polarity_reg <= wdata[2:0];
        if (!config_reg[`CFG_BLOCK_POL_MIR_BIT])
          mirror_reg <= (mirror_reg & ~(wdata[2:0] ^ polarity_reg))
                        | (wdata[2:0] & (wdata[2:0] ^ polarity_reg));
      end
      if (wr_hit(addr, `ADDR_DRIVE_REQUEST))
        drive_reg <= wdata[2:0];
      if (wr_hit(addr, `ADDR_LINK_TRANSITION))
        transition_reg <= wdata[2:0];
      if (wr_hit(addr, `ADDR_DUTY_MIRROR))
        mirror_reg <= wdata[2:0];
      if (wr_hit(addr, `ADDR_BEHAVIOR))
        behavior_reg <= wdata[5:0];
      if (wr_hit(addr, `ADDR_DUTY_LIMITS)) begin
        min_duty_reg <= wdata[3:0];
        max_duty_reg <= wdata[7:4];
      end
      if (wr_hit(addr, `ADDR_CONFIG))
        config_reg <= wdata[1:0];
    end
  end

  // Read data one cycle after strobe; unmapped reads return zero
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `ADDR_LINK_ENABLE:     rdata <= {5'h00, link_reg};
        `ADDR_POLARITY:        rdata <= {5'h00, polarity_reg};
        `ADDR_DRIVE_REQUEST:   rdata <= {5'h00, drive_reg};
        `ADDR_LINK_TRANSITION: rdata <= {5'h00, transition_reg};
        `ADDR_DUTY_MIRROR:     rdata <= {5'h00, mirror_reg};
        `ADDR_BEHAVIOR:        rdata <= {2'h0, behavior_reg};
        `ADDR_DUTY_LIMITS:     rdata <= {max_duty_reg, min_duty_reg};
        `ADDR_CONFIG:          rdata <= {6'h00, config_reg};
        `ADDR_LAMP_STATE:      rdata <= {5'h00, actuate_reg};
        default:               rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // Touch pins arrive asynchronously
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      touch_meta_reg <= 3'h0;
      touch_sync_reg <= 3'h0;
      touch_prev_reg <= 3'h0;
      link_prev_reg  <= 3'h0;
    end else begin
      touch_meta_reg <= touch_raw;
      touch_sync_reg <= touch_meta_reg;
      touch_prev_reg <= touch_sync_reg;
      link_prev_reg  <= link_reg;
    end
  end

  // Actuation source select; hold keeps host state across a smooth link
  always @* begin
    actuate_next = 3'h0;
    for (j = 0; j < 3; j = j + 1) begin
      if (!link_reg[j]) begin
        actuate_next[j] = drive_reg[j];
      end else if (new_link[j] && drive_reg[j] && transition_reg[j]) begin
        actuate_next[j] = 1'b1;
      end else if (hold_reg[j] && !(new_link[j])) begin
        // Touch edge flips the held lamp off; it stays so until unlinked
        if (config_reg[`CFG_INV_LINK_BIT] && touch_sync_reg[j] && !touch_prev_reg[j])
          actuate_next[j] = 1'b0;
        else
          actuate_next[j] = actuate_reg[j];
      end else begin
        actuate_next[j] = touch_sync_reg[j];
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      actuate_reg <= 3'h0;
      hold_reg    <= 3'h0;
    end else begin
      actuate_reg <= actuate_next;
      for (i = 0; i < 3; i = i + 1) begin
        if (!link_reg[i])
          hold_reg[i] <= 1'b0;
        else if (new_link[i])
          hold_reg[i] <= drive_reg[i] & transition_reg[i];
      end
    end
  end

  // PWM step enable from a divider; one clock only
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_reg   <= 8'h00;
      tick_reg  <= 1'b0;
      phase_reg <= 4'h0;
    end else begin
      tick_reg <= (div_reg == TICK_DIV - 8'h01);
      if (div_reg == TICK_DIV - 8'h01)
        div_reg <= 8'h00;
      else
        div_reg <= div_reg + 8'h01;
      if (tick_reg)
        phase_reg <= phase_reg + 4'h1;
    end
  end

  // Duty: minimum when idle, maximum when actuated, referenced by mirror
  always @* begin
    for (m = 0; m < 3; m = m + 1) begin
      duty_sel[m] = ref_duty(actuate_reg[m] ? max_duty_reg : min_duty_reg,
                             mirror_reg[m]);
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : lamp
      lamp_pwm #(
        .STEP_BITS (STEP_BITS)
      ) u_pwm (
        .clk        (clk),
        .nrst       (nrst),
        .tick       (tick_reg),
        .phase      (phase_reg),
        .duty       (duty_sel[g]),
        .full       (duty_sel[g] == 4'hf),
        .active_reg (pwm_active[g])
      );
    end
  endgenerate

  // Polarity bit set: active time is high; polarity bit clear: active time is low
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lamp_out  <= 3'h7;
      lamp_oe_n <= 3'h0;
    end else begin
      lamp_out  <= polarity_reg ^ ~pwm_active;
      lamp_oe_n <= 3'h0;
    end
  end
endmodule

// ### testbench/indicator_drive_control_sva.sv
// Port checker for the indicator drive block
module indicator_drive_control_sva (
  input wire       clk,
  input wire       nrst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  input wire [2:0] lamp_out,
  input wire [2:0] lamp_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] drv_sh;
  logic [2:0] lnk_sh;
  logic [2:0] trn_sh;
  // Shadows of plain storage bits only; mirror auto-update is left to the bench
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drv_sh <= 3'h0;
      lnk_sh <= 3'h0;
      trn_sh <= 3'h0;
    end else if (wr) begin
      if (addr == 8'h74) drv_sh <= wdata[2:0];
      if (addr == 8'h72) lnk_sh <= wdata[2:0];
      if (addr == 8'h77) trn_sh <= wdata[2:0];
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_oe_low: assert property (lamp_oe_n == 3'h0)
    else $error("lamp enable not driven");
  a_rd_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside read slot");
  a_drive_read: assert property (rd && addr == 8'h74 |=> rdata == {5'h00, drv_sh})
    else $error("drive request readback wrong");
  a_link_read: assert property (rd && addr == 8'h72 |=> rdata == {5'h00, lnk_sh})
    else $error("link readback wrong");
  a_trans_read: assert property (rd && addr == 8'h77 |=> rdata == {5'h00, trn_sh})
    else $error("transition readback wrong");
  a_upper_zero: assert property (rd && addr inside {8'h72, 8'h73, 8'h74, 8'h77, 8'h79}
    |=> rdata[7:3] == 5'h00)
    else $error("unused bits not zero");
  a_unmapped_zero: assert property (rd && addr == 8'h00 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reset_lamp: assert property (!$past(nrst) |-> lamp_out == 3'h7)
    else $error("lamp not idle after reset");
endmodule
bind indicator_drive_control indicator_drive_control_sva chk (.clk(clk), .nrst(nrst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .lamp_out(lamp_out),
  .lamp_oe_n(lamp_oe_n));

// ### testbench/touch_pad_model.sv
// Touch pad model driving the three touch levels
module touch_pad_model (
  input  wire       clk,
  input  wire [2:0] press,
  output logic      touch_input_1,
  output logic      touch_input_2,
  output logic      touch_input_3
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {touch_input_3, touch_input_2, touch_input_1} = 3'h0;
  // Pads move mid-cycle, on the falling edge, half a cycle from the sampling edge
  always @(negedge clk) begin
    {touch_input_3, touch_input_2, touch_input_1} <= press;
  end
endmodule

// ### testbench/test_indicator_drive_control.sv
// Self-checking bench for the indicator drive block
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module test_indicator_drive_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [2:0] press = 3'h0;
  wire  [7:0] rdata;
  wire  [2:0] lamp_out;
  wire  [2:0] lamp_oe_n;
  wire        t1, t2, t3;
  int         fail_count = 0;
  int         num_checks = 0;
  logic [2:0] drv, lnk, trn, pol, mir, hold, tog;
  logic [1:0] cfg;
  logic [7:0] d8;
  logic [7:0] regs [6] = '{8'h72, 8'h73, 8'h74, 8'h77, 8'h79, 8'h00};
  indicator_drive_control #(.TICK_DIV(8'h02)) uut (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .touch_input_1(t1), .touch_input_2(t2),
    .touch_input_3(t3), .lamp_out(lamp_out), .lamp_oe_n(lamp_oe_n));
  touch_pad_model pads (.clk(clk), .press(press), .touch_input_1(t1), .touch_input_2(t2),
    .touch_input_3(t3));
  initial begin
    forever #20 clk = ~clk;
  end
  function automatic logic [2:0] act();
    return (lnk & ((hold & ~tog) | (~hold & press))) | (~lnk & drv);
  endfunction
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    case (a)
      8'h72: begin
        hold = (hold | (d[2:0] & ~lnk & drv & trn & ~press)) & d[2:0];
        tog = tog & d[2:0];
        lnk = d[2:0];
      end
      8'h73: begin
        if (!cfg[1]) mir = (mir & ~(pol ^ d[2:0])) | (d[2:0] & (pol ^ d[2:0]));
        pol = d[2:0];
      end
      8'h74: drv = d[2:0];
      8'h77: trn = d[2:0];
      8'h79: mir = d[2:0];
      8'h91: cfg = d[1:0];
      default: ;
    endcase
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK("rdata", e, rdata)
    @(posedge clk);
  endtask
  task automatic touch(input logic [2:0] p);
    tog = tog | (hold & p & ~press & {3{cfg[0]}});
    press <= p;
    @(posedge clk);
  endtask
  // Longer than one full pulse period, so the pins have settled
  task automatic settle();
    repeat (40) @(posedge clk);
    rreg(8'h92, {5'h00, act()});
    #1 `CHK("lamp_out", ~(act() ^ mir ^ pol), lamp_out)
    `CHK("lamp_oe_n", 3'h0, lamp_oe_n)
  endtask
  task automatic end_sim();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hbe8f87a5));
    {drv, lnk, trn, pol, mir, hold, tog, cfg} = '0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    foreach (regs[i]) rreg(regs[i], 8'h00);
    settle();
    for (int i = 2; i < 5; i++) begin
      repeat (2) begin
        d8 = $urandom;
        wreg(regs[i], d8);
        rreg(regs[i], {5'h00, d8[2:0]});
        settle();
      end
    end
    repeat (6) begin
      d8 = $urandom;
      wreg(8'h91, d8 & 8'h02);
      wreg(8'h73, $urandom);
      rreg(8'h79, {5'h00, mir});
      settle();
    end
    {d8[0], d8[1]} = 2'b00;
    wreg(8'h91, 8'h00);
    wreg(8'h73, 8'h00);
    wreg(8'h79, 8'h00);
    for (int k = 0; k < 3; k++) begin
      wreg(8'h74, 8'h07);
      wreg(8'h77, k == 0 ? 8'h00 : 8'h07);
      wreg(8'h91, k == 1 ? 8'h01 : 8'h00);
      wreg(8'h72, 8'h07);
      wreg(8'h74, 8'h00);
      settle();
      touch(3'h5);
      settle();
      wreg(8'h72, 8'h00);
      touch(3'h0);
      settle();
    end
    end_sim();
  end
endmodule
